// ---- common/bphr_cfg.svh ----
// Constants of the primary header register bank: offsets, field positions,
// reset values. Assumes a single 250 MHz clock and an AHB-Lite register bus.
// Behaviour
// (R1) Bits 15:8 of the dword at 0Ch hold an eight-bit primary latency timer.
// (R2) In forward bridge mode the latency timer is read-only, reads 00h and ignores writes.
// (R3) In reverse bridge PCI mode the latency timer is host-writable and resets to 00h.
// (R4) Bits 22:16 give a read-only type-0 header format code that is zero in this mode.
// (R5) Bit 23 reads zero for a single-function device and bits 31:24 read zero.
// (R6) Base bit 0 reads zero (memory) and bits 2:1 give the read-only address type, 00 at reset.
// (R7) Base bit 3 is the read-only prefetchable flag, 0 at reset, and bits 11:4 read zero.
// (R8) Size and type of the base register come from the external memory-0 setup register.
// (R9) The window size spans 4KB to 2GB as the setup register sets it.
// (R10) The lowest 4KB of the claimed window decode as the bank's own control registers.
// (R11) Window space above the lowest 4KB is forwarded downstream.
// (R12) Forwarded addresses are translated using the memory-0 translated base register.
// (R13) Base bits 31:12 are writable only where the setup bit is one, else zero, reset zero.
// (R14) Writes to read-only and reserved bits are ignored and reads give fixed values.
`ifndef BPHR_CFG_SVH
`define BPHR_CFG_SVH

// Register byte offsets
`define BPHR_OFF_HDR 8'h0C
`define BPHR_OFF_BAR 8'h10
`define BPHR_OFF_XLAT 8'h98
`define BPHR_OFF_SETUP 8'h9C

// Field positions
`define BPHR_LAT_LSB 8
`define BPHR_LAT_MSB 15
`define BPHR_BASE_LSB 12
`define BPHR_BASE_MSB 31
`define BPHR_WIN_MSB 19

// Reset and fixed values
`define BPHR_LAT_RST 8'h00
`define BPHR_HDR_CODE 7'h00
`define BPHR_BASE_RST 20'h00000
`define BPHR_RDATA_RST 32'h00000000

// AHB encodings
`define BPHR_HSIZE_BYTE 3'h0
`define BPHR_HSIZE_HALF 3'h1

`endif

// ---- common/bphr_pkg.sv ----
// Types shared by the primary header register bank.
// Assumes bphr_cfg.svh supplies the numeric constants.
package bphr_pkg;
    // Upper base address field, bits 31:12
    typedef logic [19:0] bphr_base_t;
    // Kind of AHB data phase in flight
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_WRITE,
        PH_READ
    } bphr_phase_t;
endpackage : bphr_pkg

// ---- rtl/bphr_regs.sv ----
// Primary header registers and memory-0 window decode of the bridge.
// Assumes one clock, an AHB-Lite master, setup and translated base words
// from same-clock logic and mode straps from pins.
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "bphr_cfg.svh"

module bphr_regs #(
    parameter int HADDR_W = 12
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [HADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Mode straps from pins
    input wire logic reverseBridge,
    input wire logic pciMode,
    // External setup and translation registers
    input wire logic [31:0] mem0Setup,
    input wire logic [31:0] mem0XlatBase,
    // Memory transaction address to decode
    input wire logic txnValid,
    input wire logic [31:0] txnAddr,
    // Decode results
    output logic csrHit,
    output logic fwdHit,
    output logic [31:0] fwdAddr,
    output logic setupValid
);

    // Offsets need at least eight address bits
    if (HADDR_W < 8 || HADDR_W > 32) begin : g_chk
        $error("bphr_regs: HADDR_W must be 8 to 32");
    end

    // Straps are pins, so two stages come before any logic reads them
    // Strap synchronisers, first stage read only by the second
    logic [1:0] revSync_q;
    logic [1:0] pciSync_q;
    logic latWritable;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            revSync_q <= 2'h0;
            pciSync_q <= 2'h0;
        end else begin
            revSync_q <= {revSync_q[0], reverseBridge};
            pciSync_q <= {pciSync_q[0], pciMode};
        end
    end

    // Writable only as a reverse bridge in PCI mode
    assign latWritable = revSync_q[1] & pciSync_q[1]; // [R2] [R3]

    // Address phase decode
    wire addrPhase = hsel & htrans[1] & hready;
    wire [7:0] reqOff = {haddr[7:2], 2'h0};
    wire reqHigh = (HADDR_W > 8) ? |(haddr >> 8) : 1'b0;
    wire reqHdr = !reqHigh && (reqOff == `BPHR_OFF_HDR);
    wire reqBar = !reqHigh && (reqOff == `BPHR_OFF_BAR);

    // Byte lanes from size and low address bits
    logic [3:0] reqLanes;
    always_comb begin
        reqLanes = 4'hF;
        if (hsize == `BPHR_HSIZE_BYTE) begin
            reqLanes = 4'h1 << haddr[1:0];
        end else if (hsize == `BPHR_HSIZE_HALF) begin
            reqLanes = haddr[1] ? 4'hC : 4'h3;
        end
    end

    // Data phase tracking
    bphr_pkg::bphr_phase_t phase_q;
    bphr_pkg::bphr_phase_t phase_d;
    logic dpHdr_q;
    logic dpBar_q;
    logic [3:0] dpLanes_q;

    // Next phase kind from the request in the address phase
    always_comb begin
        phase_d = bphr_pkg::PH_IDLE;
        if (addrPhase) begin
            phase_d = hwrite ? bphr_pkg::PH_WRITE : bphr_pkg::PH_READ;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_q <= bphr_pkg::PH_IDLE;
            dpHdr_q <= 1'b0;
            dpBar_q <= 1'b0;
            dpLanes_q <= 4'h0;
        end else begin
            phase_q <= phase_d;
            dpHdr_q <= reqHdr;
            dpBar_q <= reqBar;
            dpLanes_q <= reqLanes;
        end
    end

    // Write strobes in the data phase
    logic dpWrite;
    always_comb begin
        case (phase_q)
            bphr_pkg::PH_WRITE: dpWrite = 1'b1;
            bphr_pkg::PH_READ: dpWrite = 1'b0;
            bphr_pkg::PH_IDLE: dpWrite = 1'b0;
            default: dpWrite = 1'b0;
        endcase
    end
    wire wrLat = dpWrite & dpHdr_q & dpLanes_q[1] & latWritable; // [R3]
    wire wrBar = dpWrite & dpBar_q;

    // Latency timer byte
    logic [7:0] latency_q;
    logic [7:0] latency_d;
    always_comb begin
        latency_d = latency_q;
        if (!latWritable) begin
            latency_d = `BPHR_LAT_RST; // [R2]
        end else if (wrLat) begin
            latency_d = hwdata[`BPHR_LAT_MSB:`BPHR_LAT_LSB]; // [R1] [R3]
        end
    end

    // Base field storage, declared ahead of the merge that reads it
    bphr_pkg::bphr_base_t base_q;
    bphr_pkg::bphr_base_t base_d;

    // Writable base bits follow the setup word
    wire bphr_pkg::bphr_base_t baseMask = mem0Setup[`BPHR_BASE_MSB:`BPHR_BASE_LSB]; // [R8]
    wire [31:0] laneMask = {{8{dpLanes_q[3]}}, {8{dpLanes_q[2]}},
        {8{dpLanes_q[1]}}, {8{dpLanes_q[0]}}};
    wire [31:0] barMerged = (hwdata & laneMask) | ({base_q, 12'h000} & ~laneMask);

    // Base field; masking also clears bits when the window grows
    always_comb begin
        base_d = base_q;
        if (wrBar) begin
            base_d = barMerged[`BPHR_BASE_MSB:`BPHR_BASE_LSB];
        end
        base_d = base_d & baseMask; // [R13] [R14]
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            latency_q <= `BPHR_LAT_RST;
            base_q <= `BPHR_BASE_RST;
        end else begin
            latency_q <= latency_d;
            base_q <= base_d;
        end
    end

    // Read words built from next values so a read right after a write sees it
    wire [31:0] hdrWord = {8'h00, 1'b0, `BPHR_HDR_CODE, latency_d, 8'h00}; // [R4] [R5]
    // Type and prefetch mirror the setup word, space bit fixed at memory
    wire [31:0] barWord = {base_d, 8'h00, mem0Setup[3:1], 1'b0}; // [R6] [R7] [R8]
    wire [31:0] rdWord = reqHdr ? hdrWord : (reqBar ? barWord : 32'h00000000); // [R14]

    // Bus answer: zero wait, always OKAY
    // Constant answers still come from flops so every output is registered
    logic [31:0] hrdata_q;
    logic hreadyout_q;
    logic hresp_q;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hrdata_q <= `BPHR_RDATA_RST;
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end else begin
            hrdata_q <= (addrPhase && !hwrite) ? rdWord : `BPHR_RDATA_RST;
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end
    end
    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = hresp_q;

    // Setup must be ones from bit 31 down: 4KB to 2GB
    wire bphr_pkg::bphr_base_t invMask = ~baseMask;
    wire bphr_pkg::bphr_base_t invInc = invMask + 20'h00001;
    wire maskOk = baseMask[`BPHR_WIN_MSB] && ((invInc & invMask) == 20'h00000); // [R9]

    // Window hit and its split at 4KB
    wire bphr_pkg::bphr_base_t txnBase = txnAddr[`BPHR_BASE_MSB:`BPHR_BASE_LSB];
    wire inWindow = maskOk && ((txnBase & baseMask) == base_q); // [R9]
    wire lowPage = ((txnBase & invMask) == 20'h00000);
    wire csrHit_d = txnValid && inWindow && lowPage; // [R10]
    wire fwdHit_d = txnValid && inWindow && !lowPage; // [R11]
    // Upper bits replaced by translated base, offset kept
    wire bphr_pkg::bphr_base_t xlatHigh =
        (mem0XlatBase[`BPHR_BASE_MSB:`BPHR_BASE_LSB] & baseMask) | (txnBase & invMask);
    wire [31:0] fwdAddr_d = {xlatHigh, txnAddr[11:0]}; // [R12]

    // Decode outputs registered one cycle after the request
    logic csrHit_q;
    logic fwdHit_q;
    logic [31:0] fwdAddr_q;
    logic setupValid_q;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            csrHit_q <= 1'b0;
            fwdHit_q <= 1'b0;
            fwdAddr_q <= 32'h00000000;
            setupValid_q <= 1'b0;
        end else begin
            csrHit_q <= csrHit_d;
            fwdHit_q <= fwdHit_d;
            fwdAddr_q <= fwdHit_d ? fwdAddr_d : 32'h00000000;
            setupValid_q <= maskOk;
        end
    end
    assign csrHit = csrHit_q;
    assign fwdHit = fwdHit_q;
    assign fwdAddr = fwdAddr_q;
    assign setupValid = setupValid_q;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // Write to the header word with lane 1 live
    sequence sLatWrite;
        addrPhase && hwrite && reqHdr && reqLanes[1] ##1 latWritable;
    endsequence

    AST_LAT_FWD_RO: assert property ( // [R2]
        !latWritable |=> latency_q == 8'h00)
        else $error("latency timer not zero in forward mode");

    AST_LAT_REV_WR: assert property ( // [R3]
        sLatWrite |=> latency_q == $past(hwdata[15:8]))
        else $error("latency timer write lost in reverse mode");

    AST_HDR_FIXED: assert property ( // [R4]
        addrPhase && !hwrite && reqHdr |=> hrdata[31:16] == 16'h0000 && hrdata[7:0] == 8'h00)
        else $error("header word fixed bits not zero");

    AST_HDR_LAT_READ: assert property ( // [R1]
        addrPhase && !hwrite && reqHdr ##1 !dpWrite |-> hrdata[15:8] == latency_q)
        else $error("latency read mismatch");

    AST_BAR_LOW: assert property ( // [R7]
        addrPhase && !hwrite && reqBar |=> hrdata[11:4] == 8'h00 && hrdata[0] == 1'b0)
        else $error("base low bits not fixed");

    AST_BAR_TYPE: assert property ( // [R6]
        addrPhase && !hwrite && reqBar |=> hrdata[3:1] == $past(mem0Setup[3:1]))
        else $error("base type bits do not follow setup");

    AST_BAR_MASK: assert property ( // [R13]
        (base_q & ~baseMask) == 20'h00000 || $changed(mem0Setup))
        else $error("base bit set where setup bit is zero");

    AST_RO_IGNORED: assert property ( // [R14]
        wrBar && $stable(mem0Setup) |=> (base_q & ~$past(baseMask)) == 20'h00000)
        else $error("write reached a read-only base bit");

    AST_CSR_HIT: assert property ( // [R10]
        txnValid && maskOk && (txnBase & baseMask) == base_q && (txnBase & invMask) == 20'h00000
        |=> csrHit && !fwdHit)
        else $error("low page not decoded as control space");

    AST_FWD_XLAT: assert property ( // [R11]
        fwdHit_d |=> fwdHit && !csrHit && fwdAddr[11:0] == $past(txnAddr[11:0]))
        else $error("forwarded hit or offset wrong");

    AST_XLAT_BASE: assert property ( // [R12]
        fwdHit_d |=> (fwdAddr[31:12] & $past(baseMask)) ==
            ($past(mem0XlatBase[31:12]) & $past(baseMask)))
        else $error("translated base not applied");

    AST_SIZE_RANGE: assert property ( // [R9]
        !mem0Setup[31] |=> !csrHit && !fwdHit)
        else $error("window claimed with setup below range");

    // Bus answers: zero wait and never an error
    AST_BUS_OKAY: assert property ( // [R14]
        hreadyout && !hresp)
        else $error("bus answer not ready or not okay");

    // Read data stands one cycle, else the bus sees zero
    AST_RDATA_IDLE: assert property ( // [R14]
        !(addrPhase && !hwrite) |=> hrdata == 32'h00000000)
        else $error("read data not zero outside a read");

    AST_UNMAPPED_ZERO: assert property ( // [R14]
        addrPhase && !hwrite && !reqHdr && !reqBar |=> hrdata == 32'h00000000)
        else $error("unmapped offset read not zero");

    // Latency byte keeps its value between writes
    AST_LAT_HOLD: assert property ( // [R3]
        latWritable && !wrLat |=> latency_q == $past(latency_q))
        else $error("latency timer changed without a write");

    // Header write while the timer is read-only
    sequence sLatFwdWrite;
        addrPhase && hwrite && reqHdr ##1 !latWritable;
    endsequence

    AST_LAT_FWD_IGNORE: assert property ( // [R2]
        sLatFwdWrite |=> latency_q == 8'h00)
        else $error("latency timer took a write in forward mode");

    // Whole-word write to the base word, then the data phase that carries it
    sequence sBarWordWrite;
        addrPhase && hwrite && reqBar && reqLanes == 4'hF ##1 dpWrite;
    endsequence

    AST_BAR_WRITE: assert property ( // [R13]
        sBarWordWrite |=> base_q == ($past(hwdata[31:12]) & $past(baseMask)))
        else $error("base write did not land on writable bits");

    // Base holds while neither a write nor a setup change touches it
    AST_BASE_HOLD: assert property ( // [R13]
        !wrBar && $stable(mem0Setup) |=> base_q == $past(base_q))
        else $error("base changed without a write");

    // Decode outputs
    AST_HIT_EXCL: assert property ( // [R11]
        !(csrHit && fwdHit))
        else $error("control and forward hits together");

    AST_FWD_IDLE_ZERO: assert property ( // [R12]
        !fwdHit |-> fwdAddr == 32'h00000000)
        else $error("translated address shown without a forward hit");

    AST_CSR_NO_ADDR: assert property ( // [R10]
        csrHit |-> fwdAddr == 32'h00000000)
        else $error("control space hit shows a translated address");

    AST_OUT_WINDOW: assert property ( // [R9]
        txnValid && !inWindow |=> !csrHit && !fwdHit)
        else $error("address outside the window claimed");

    // Valid setup always has its top bit, the 2GB end of the range
    AST_SETUP_FLAG: assert property ( // [R9]
        setupValid |-> $past(mem0Setup[31]))
        else $error("setup flagged valid without its top bit");

endmodule : bphr_regs

// ---- testbench/bphr_host.sv ----
// Primary-side configuration host: an AHB-Lite master doing single word transfers.
// Assumes the bank's hreadyout is fed back as the bus hready.
`timescale 1ns/1ps
module bphr_host (
    // Clock
    input wire logic clk,
    // AHB-Lite master
    output logic hsel,
    output logic [11:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata
);
    // Idle bus at time zero
    initial begin
        hsel = 1'b0;
        haddr = 12'h000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
    end

    // One transfer; entered just after a rising edge, waits for hready at each phase
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        haddr <= ~a; // Released address no longer shows the old value
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        r = hrdata;
        hwdata <= ~d; // Stale data inverted so a late sample is caught
    endtask : xfer
endmodule : bphr_host

// ---- testbench/bphr_regs_tb_top.sv ----
// Self-checking bench of the primary header bank and its window decode.
// Assumes bphr_host as bus master and a 250 MHz clock.
`timescale 1ns/1ps
module bphr_regs_tb_top;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic hsel, hwrite, hready, hreadyout, hresp, csrHit, fwdHit, setupValid;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, fwdAddr, r, d, mask, off, a, gotAddr;
    logic [1:0] gotHits;
    logic reverseBridge = 1'b0, pciMode = 1'b0, txnValid = 1'b0;
    logic [31:0] mem0Setup = 32'h00000000, mem0XlatBase = 32'h00000000, txnAddr = 32'h00000000;
    integer seed = 32'h2DE6, errorCnt = 0, checked = 0, cycles = 0, k;
    // Reference model of the two words, from the rules alone
    int mdlLat = 0, mdlBase = 0;
    logic [31:0] expQ[$];

    assign hready = hreadyout;
    always #2 clk = ~clk;

    // Hang guard: the whole run needs under two hundred cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errorCnt++;
            summarize();
        end
    end

    bphr_host host (.clk, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata);
    bphr_regs dut (.clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hreadyout, .hresp, .hrdata, .reverseBridge, .pciMode, .mem0Setup, .mem0XlatBase,
        .txnValid, .txnAddr, .csrHit, .fwdHit, .fwdAddr, .setupValid);

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            errorCnt++;
            $display("BAD %0t got %h expected %h", $time, g, e);
        end
    endtask : chk

    // Expected read word from the model
    function automatic logic [31:0] expWord(input logic [11:0] ea);
        if (ea == 12'h00C)
            return mdlLat << 8;
        if (ea == 12'h010)
            return (mdlBase & mem0Setup & 32'hFFFFF000) | (mem0Setup & 32'h0000000E);
        return 32'h00000000;
    endfunction : expWord

    // Write through the host, then mirror it in the model once setup has settled
    task automatic wr(input logic [11:0] wa, input logic [31:0] wd);
        host.xfer(1'b1, wa, wd, r);
        if (wa == 12'h00C && reverseBridge && pciMode)
            mdlLat = wd[15:8];
        if (wa == 12'h010)
            mdlBase = wd & mem0Setup & 32'hFFFFF000;
    endtask : wr

    // Read through the host; expected word queued from the model first
    task automatic rd(input logic [11:0] ra);
        expQ.push_back(expWord(ra));
        host.xfer(1'b0, ra, 32'h00000000, r);
        chk(r, expQ.pop_front());
    endtask : rd

    // One decode request; results registered one cycle later
    task automatic decode(input logic [31:0] ad);
        txnValid <= 1'b1;
        txnAddr <= ad;
        @(posedge clk);
        txnValid <= 1'b0;
        txnAddr <= ~ad;
        #1;
        gotHits = {csrHit, fwdHit};
        gotAddr = fwdAddr;
        @(posedge clk);
    endtask : decode

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", checked, errorCnt);
        if (errorCnt == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize

    initial begin
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rd(12'h00C);
        chk(r, 32'h00000000);
        rd(12'h010);
        chk(r, 32'h00000000);
        $display("test reset values done");
        // Forward bridge: timer stays zero, fixed fields ignore ones
        d = $random(seed);
        wr(12'h00C, d | 32'hFFFF00FF);
        rd(12'h00C);
        chk(r, 32'h00000000);
        reverseBridge <= 1'b1;
        pciMode <= 1'b1;
        repeat (4) @(posedge clk);
        wr(12'h00C, d);
        rd(12'h00C);
        chk(r, {16'h0000, d[15:8], 8'h00});
        $display("test latency timer done");
        // Every window size from 4KB to 2GB, with a decode inside each
        for (k = 12; k < 32; k++) begin
            mask = 32'hFFFFFFFF << k;
            mem0Setup <= mask | ($random(seed) & 32'h0000000E);
            mem0XlatBase <= $random(seed);
            d = $random(seed);
            wr(12'h010, d);
            rd(12'h010);
            chk(r, (d & mask) | (mem0Setup & 32'h0000000E));
            chk({31'h0, setupValid}, 32'h00000001);
            off = $random(seed) & ~mask;
            if (($random(seed) & 1) == 1)
                off = off & 32'h00000FFF;
            a = (d & mask) | off;
            decode(a);
            chk({30'h0, gotHits}, (off < 4096) ? 32'h2 : 32'h1);
            chk(gotAddr, (off < 4096) ? 32'h0 : (mem0XlatBase & mask) | (a & ~mask));
        end
        $display("test window sizes done");
        // Reset in mid-run with both words loaded; straps stay high
        wr(12'h00C, 32'h0000FF00);
        wr(12'h010, 32'hFFFFFFFF);
        reset_n <= 1'b0;
        mdlLat = 0;
        mdlBase = 0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        rd(12'h00C);
        chk(r, 32'h00000000);
        rd(12'h010);
        chk(r & 32'hFFFFF001, 32'h00000000);
        $display("test mid-run reset done");
        // Setup not of contiguous form claims nothing
        mem0Setup <= 32'hA0000000;
        wr(12'h020, 32'hFFFFFFFF);
        rd(12'h020);
        chk(r, 32'h00000000);
        decode(32'h00000010);
        chk({31'h0, setupValid}, 32'h00000000);
        chk({30'h0, gotHits}, 32'h0);
        chk({31'h0, hresp}, 32'h00000000);
        chk({31'h0, hreadyout}, 32'h00000001);
        $display("test odd setup and unmapped done");
        summarize();
    end
endmodule : bphr_regs_tb_top
